// file: logic/src_ctrl.sv
`timescale 1ns/1ps

// Operation
// - Urgent flag makes the command finish fast, never past the limit
// - Continuous-read flag: read or transfer errors never abort
// - Continuous errors: full count moved, stream error set, log error type
// - Continuous read and limit expiry: stop, stream error, log timeout
// - Without continuous read, errors end the command with the error flag set
// - Always try to move the whole count within the limit
// - Resume flag starts at the stream's last reported error address
// - Low three feature bits select the stream
// - Limit is previous feature byte times identify words, microseconds
// - Zero byte uses stream default; zero default means no limit
// - Limit timed from command write to completion interrupt
// - Requested limit below minimum is raised to the minimum
// - Count is previous:current bytes; zero means 65,536 sectors
// - 48-bit address assembled from the three register pairs
// - Address registers return first unrecoverable error, selected by hob
// - Fault bit 0 set whenever the limit has expired
// - Continuous error sets status bit 5, loads bad address and count
// - Continuous read: error bits go to the log, error flag clear
// - Opcode 2Bh is the non-DMA streaming read
module src_ctrl
    import src_pkg::*;
#(
    parameter logic [31:0] RST_IDENT = 32'h0000_0001,
    parameter logic [LIM_W-1:0] MIN_LIMIT_US = 40'h00_0000_03E8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Media engine
    output logic media_start_o,
    output logic media_stop_o,
    output logic [LBA_W-1:0] media_lba_o,
    output logic [CNT_W-1:0] media_count_o,
    output logic media_urgent_o,
    output logic media_continuous_o,
    output logic media_not_seq_o,
    output logic media_resume_o,
    output logic [STREAM_W-1:0] media_stream_o,
    input wire logic sector_done_i,
    input wire logic sector_bad_i,
    input wire logic [3:0] sector_fault_i,
    // Completion to host
    output logic intrq_o
);

    ////////////////////////////////////////////////////////////////////////
    src_state_e st_ff;
    logic [7:0] feat_cur_ff, feat_prev_ff, cnt_cur_ff, cnt_prev_ff;
    logic [7:0] addr_cur_ff [3];
    logic [7:0] addr_prev_ff [3];
    logic [7:0] drive_ff, fault_ff, log_ff;
    logic hob_ff, se_ff, err_ff;
    logic [31:0] ident_ff;
    logic [7:0] def_lim_ff [STREAMS];
    logic [LBA_W-1:0] resume_ff [STREAMS];
    logic cont_ff, limit_on_ff, had_err_ff, run_open_ff;
    logic [STREAM_W-1:0] stream_ff;
    logic [LIM_W-1:0] limit_ff, us_ff;
    logic [$clog2(CYC_PER_US)-1:0] div_ff;
    logic [LBA_W-1:0] start_lba_ff, first_bad_ff;
    logic [CNT_W-1:0] remain_ff, done_ff, run_cnt_ff;
    function automatic logic [7:0] map_fault(input logic [3:0] f);
        logic [7:0] m;
        m = 8'h00;
        m[EB_INTERFACE_CRC_ERROR] = f[FI_INTERFACE_CRC_ERROR];
        m[EB_UNC] = f[FI_UNC];
        m[EB_ID_NOT_FOUND_ERROR] = f[FI_ID_NOT_FOUND_ERROR];
        m[EB_ABORTED_ERROR] = f[FI_ABORTED_ERROR];
        return m;
    endfunction : map_fault

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: ack one cycle after request, writes land on the ack edge
    logic wr_en;
    assign wr_en = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
    function automatic logic wr_hit(input logic [7:0] off);
        return wr_en && (wb_adr_i == off);
    endfunction : wr_hit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command decode and limit computation
    logic cmd_wr, busy, expired;
    logic [LBA_W-1:0] req_lba, cur_lba, report_lba;
    logic [CNT_W-1:0] req_count, nxt_run_cnt;
    logic [7:0] units;
    logic [LIM_W-1:0] raw_limit, req_limit;
    logic [STREAM_W-1:0] req_stream;
    assign busy = (st_ff == ST_RUN);
    // Task-file writes are ignored while a command runs
    assign cmd_wr = wr_hit(OFF_OPCODE) && !busy
        && (wb_dat_i[7:0] == OPC_STREAM_DMA
        || wb_dat_i[7:0] == OPC_STREAM_PIO);
    assign req_stream = feat_cur_ff[STREAM_W-1:0];
    assign req_lba = {addr_prev_ff[2], addr_prev_ff[1], addr_prev_ff[0],
        addr_cur_ff[2], addr_cur_ff[1], addr_cur_ff[0]};
    assign req_count = ({cnt_prev_ff, cnt_cur_ff} == 16'h0000) ? FULL_COUNT
        : {1'b0, cnt_prev_ff, cnt_cur_ff};
    assign units = (feat_prev_ff == 8'h00) ? def_lim_ff[req_stream]
        : feat_prev_ff;
    assign raw_limit = LIM_W'(units) * LIM_W'(ident_ff);
    assign req_limit = (raw_limit < MIN_LIMIT_US) ? MIN_LIMIT_US
        : raw_limit;
    assign expired = limit_on_ff && (us_ff >= limit_ff);
    ////////////////////////////////////////////////////////////////////////
    // Run events; a limit expiry outranks a sector event in that cycle
    logic ev_done, ev_bad, fin_timeout, fin_err, fin_full, fin, rep_valid;
    assign ev_done = busy && !expired && sector_done_i;
    assign ev_bad = ev_done && sector_bad_i;
    assign fin_timeout = busy && expired;
    assign fin_err = ev_bad && !cont_ff;
    assign fin_full = ev_done && (remain_ff == CNT_W'(1)) && !fin_err;
    assign fin = fin_timeout || fin_err || fin_full;
    assign cur_lba = start_lba_ff + LBA_W'(done_ff);
    assign report_lba = had_err_ff ? first_bad_ff : cur_lba;
    assign rep_valid = fin && (had_err_ff || ev_bad);
    assign nxt_run_cnt = (ev_bad && (run_open_ff || !had_err_ff))
        ? run_cnt_ff + CNT_W'(1) : run_cnt_ff;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= ST_IDLE;
            intrq_o <= 1'b0;
            media_stop_o <= 1'b0;
        end else begin
            intrq_o <= 1'b0;
            media_stop_o <= 1'b0;
            if (cmd_wr) begin
                st_ff <= ST_RUN;
            end else if (fin) begin
                st_ff <= ST_IDLE;
                intrq_o <= 1'b1;
                media_stop_o <= !fin_full;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            media_start_o <= 1'b0;
            media_lba_o <= '0;
            media_count_o <= '0;
            media_urgent_o <= 1'b0;
            media_continuous_o <= 1'b0;
            media_not_seq_o <= 1'b0;
            media_resume_o <= 1'b0;
            media_stream_o <= '0;
            start_lba_ff <= '0;
            stream_ff <= '0;
            cont_ff <= 1'b0;
            limit_ff <= '0;
            limit_on_ff <= 1'b0;
        end else begin
            media_start_o <= cmd_wr;
            if (cmd_wr) begin
                media_lba_o <= feat_cur_ff[FB_RESUME] ? resume_ff[req_stream]
                    : req_lba;
                start_lba_ff <= feat_cur_ff[FB_RESUME]
                    ? resume_ff[req_stream] : req_lba;
                media_count_o <= req_count;
                media_urgent_o <= feat_cur_ff[FB_URGENT];
                media_continuous_o <= feat_cur_ff[FB_CONT];
                media_not_seq_o <= feat_cur_ff[FB_NOTSEQ];
                media_resume_o <= feat_cur_ff[FB_RESUME];
                media_stream_o <= req_stream;
                stream_ff <= req_stream;
                cont_ff <= feat_cur_ff[FB_CONT];
                limit_ff <= req_limit;
                limit_on_ff <= (units != 8'h00);
            end
        end
    end
    // Microsecond timer; runs only while busy
    always_ff @(posedge clk_i) begin
        if (rst_i || cmd_wr) begin
            div_ff <= '0;
            us_ff <= '0;
        end else if (busy) begin
            if (div_ff == $bits(div_ff)'(CYC_PER_US - 1)) begin
                div_ff <= '0;
                us_ff <= us_ff + LIM_W'(1);
            end else begin
                div_ff <= div_ff + $bits(div_ff)'(1);
            end
        end
    end
    // Sector progress and bad run tracking
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            remain_ff <= '0;
            done_ff <= '0;
            had_err_ff <= 1'b0;
            run_open_ff <= 1'b0;
            run_cnt_ff <= '0;
            first_bad_ff <= '0;
        end else if (cmd_wr) begin
            remain_ff <= req_count;
            done_ff <= '0;
            had_err_ff <= 1'b0;
            run_open_ff <= 1'b0;
            run_cnt_ff <= '0;
        end else if (ev_done) begin
            remain_ff <= remain_ff - CNT_W'(1);
            done_ff <= done_ff + CNT_W'(1);
            run_cnt_ff <= nxt_run_cnt;
            run_open_ff <= sector_bad_i && (run_open_ff || !had_err_ff);
            if (sector_bad_i && !had_err_ff) begin
                had_err_ff <= 1'b1;
                first_bad_ff <= cur_lba;
            end
        end
    end
    // Last reported error per stream, for resumed commands
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < STREAMS; i++) begin
                resume_ff[i] <= '0;
            end
        end else if (rep_valid) begin
            resume_ff[stream_ff] <= report_lba;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ending status, fault flags and error log
    always_ff @(posedge clk_i) begin
        if (rst_i || cmd_wr) begin
            se_ff <= 1'b0;
            err_ff <= 1'b0;
            fault_ff <= 8'h00;
            log_ff <= 8'h00;
        end else if (busy) begin
            if (fin_timeout) begin
                fault_ff[EB_COMPLETION_TIMEOUT_BIT] <= 1'b1;
                if (cont_ff) begin
                    se_ff <= 1'b1;
                    log_ff[EB_COMPLETION_TIMEOUT_BIT] <= 1'b1;
                end else begin
                    err_ff <= 1'b1;
                end
            end else if (ev_bad && cont_ff) begin
                se_ff <= 1'b1;
                log_ff <= log_ff | map_fault(sector_fault_i);
            end else if (fin_err) begin
                err_ff <= 1'b1;
                fault_ff <= map_fault(sector_fault_i);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Task-file registers; feature, count and address writes push current into previous
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            feat_cur_ff <= 8'h00;
            feat_prev_ff <= 8'h00;
            cnt_cur_ff <= 8'h00;
            cnt_prev_ff <= 8'h00;
            drive_ff <= 8'h00;
            hob_ff <= 1'b0;
            ident_ff <= RST_IDENT;
            for (int i = 0; i < 3; i++) begin
                addr_cur_ff[i] <= 8'h00;
                addr_prev_ff[i] <= 8'h00;
            end
            for (int i = 0; i < STREAMS; i++) begin
                def_lim_ff[i] <= 8'h00;
            end
        end else if (rep_valid) begin
            {addr_prev_ff[2], addr_prev_ff[1], addr_prev_ff[0],
                addr_cur_ff[2], addr_cur_ff[1], addr_cur_ff[0]}
                <= report_lba;
            if (cont_ff) begin
                {cnt_prev_ff, cnt_cur_ff} <= nxt_run_cnt[15:0];
            end
        end else if (!busy) begin
            if (wr_hit(OFF_FEATURE)) begin
                feat_prev_ff <= feat_cur_ff;
                feat_cur_ff <= wb_dat_i[7:0];
            end
            if (wr_hit(OFF_COUNT)) begin
                cnt_prev_ff <= cnt_cur_ff;
                cnt_cur_ff <= wb_dat_i[7:0];
            end
            if (wr_hit(OFF_ADDR_LOW)) begin
                addr_prev_ff[0] <= addr_cur_ff[0];
                addr_cur_ff[0] <= wb_dat_i[7:0];
            end
            if (wr_hit(OFF_ADDR_MID)) begin
                addr_prev_ff[1] <= addr_cur_ff[1];
                addr_cur_ff[1] <= wb_dat_i[7:0];
            end
            if (wr_hit(OFF_ADDR_HIGH)) begin
                addr_prev_ff[2] <= addr_cur_ff[2];
                addr_cur_ff[2] <= wb_dat_i[7:0];
            end
            if (wr_hit(OFF_DRIVE)) begin
                drive_ff <= wb_dat_i[7:0];
            end
            if (wr_hit(OFF_HOB)) begin
                hob_ff <= wb_dat_i[HOB_BIT];
            end
            if (wr_en && wb_adr_i == OFF_IDENT && wb_sel_i == 4'hF) begin
                ident_ff <= wb_dat_i;
            end
            if (wr_en && wb_adr_i == OFF_DEFLIM && wb_sel_i[1]) begin
                def_lim_ff[wb_dat_i[DL_STREAM_LSB +: STREAM_W]]
                    <= wb_dat_i[7:0];
            end
        end
    end
    // Read mux; unmapped and write-only offsets read zero
    logic [7:0] flags;
    assign flags = {busy, 1'b1, se_ff, 4'h0, err_ff};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_dat_o <= 32'h0000_0000;
            unique case (wb_adr_i)
                OFF_COUNT: wb_dat_o[7:0] <= hob_ff ? cnt_prev_ff : cnt_cur_ff;
                OFF_ADDR_LOW: wb_dat_o[7:0] <= hob_ff ? addr_prev_ff[0]
                    : addr_cur_ff[0];
                OFF_ADDR_MID: wb_dat_o[7:0] <= hob_ff ? addr_prev_ff[1]
                    : addr_cur_ff[1];
                OFF_ADDR_HIGH: wb_dat_o[7:0] <= hob_ff ? addr_prev_ff[2]
                    : addr_cur_ff[2];
                OFF_DRIVE: wb_dat_o[7:0] <= drive_ff;
                OFF_OPCODE: wb_dat_o[7:0] <= flags;
                OFF_FAULT: wb_dat_o[7:0] <= fault_ff;
                OFF_HOB: wb_dat_o[HOB_BIT] <= hob_ff;
                OFF_IDENT: wb_dat_o <= ident_ff;
                OFF_ERRLOG: wb_dat_o[7:0] <= log_ff;
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence seq_run_end;
        busy ##1 !busy;
    endsequence
    sequence seq_cont_bad;
        busy && cont_ff && ev_bad && (remain_ff > CNT_W'(1));
    endsequence
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_end_intrq: assert property (seq_run_end |-> intrq_o)
        else $error("command ended without completion pulse");
    chk_cont_keeps: assert property (seq_cont_bad |=> busy && se_ff)
        else $error("continuous read stopped on a sector error");
    chk_plain_abort: assert property (fin_err |=> !busy && err_ff
        && !se_ff && media_stop_o)
        else $error("plain read error did not end the command");
    chk_cont_timeout: assert property (fin_timeout && cont_ff |=> !busy
        && se_ff && !err_ff && log_ff[EB_COMPLETION_TIMEOUT_BIT])
        else $error("continuous timeout ending status wrong");
    chk_timeout_fault: assert property (fin_timeout |=>
        fault_ff[EB_COMPLETION_TIMEOUT_BIT] && intrq_o)
        else $error("timeout bit missing after expiry");
    chk_limit_floor: assert property (limit_on_ff |-> limit_ff
        >= MIN_LIMIT_US)
        else $error("limit below minimum");
    chk_zero_count: assert property (cmd_wr && cnt_cur_ff == 8'h00
        && cnt_prev_ff == 8'h00 |=> media_count_o == FULL_COUNT)
        else $error("zero count not taken as full count");
    chk_stream_pick: assert property (cmd_wr |=> media_stream_o
        == $past(feat_cur_ff[STREAM_W-1:0]) && media_start_o)
        else $error("stream selector not passed on");
    chk_cont_log: assert property (ev_bad && cont_ff && !fin_timeout
        |=> !err_ff && log_ff != 8'h00)
        else $error("continuous error not logged");
endmodule : src_ctrl

// file: shared/src_pkg.sv
package src_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] OFF_FEATURE = 8'h00;
    localparam logic [7:0] OFF_COUNT = 8'h04;
    localparam logic [7:0] OFF_ADDR_LOW = 8'h08;
    localparam logic [7:0] OFF_ADDR_MID = 8'h0C;
    localparam logic [7:0] OFF_ADDR_HIGH = 8'h10;
    localparam logic [7:0] OFF_DRIVE = 8'h14;
    localparam logic [7:0] OFF_OPCODE = 8'h18;
    localparam logic [7:0] OFF_FAULT = 8'h1C;
    localparam logic [7:0] OFF_HOB = 8'h20;
    localparam logic [7:0] OFF_IDENT = 8'h24;
    localparam logic [7:0] OFF_DEFLIM = 8'h28;
    localparam logic [7:0] OFF_ERRLOG = 8'h2C;

    // Opcodes
    localparam logic [7:0] OPC_STREAM_DMA = 8'h2A;
    localparam logic [7:0] OPC_STREAM_PIO = 8'h2B;

    // Current feature byte fields
    localparam int FB_URGENT = 7;
    localparam int FB_CONT = 6;
    localparam int FB_NOTSEQ = 5;
    localparam int FB_RESUME = 4;
    localparam int STREAM_W = 3;
    localparam int STREAMS = 8;

    // State flag bits
    localparam int SB_BUSY = 7;
    localparam int SB_READY = 6;
    localparam int SB_SE = 5;
    localparam int SB_ERR = 0;

    // Fault flag and error log bits
    localparam int EB_INTERFACE_CRC_ERROR = 7;
    localparam int EB_UNC = 6;
    localparam int EB_ID_NOT_FOUND_ERROR = 4;
    localparam int EB_ABORTED_ERROR = 2;
    localparam int EB_COMPLETION_TIMEOUT_BIT = 0;

    // Fault type input bits
    localparam int FI_INTERFACE_CRC_ERROR = 3;
    localparam int FI_UNC = 2;
    localparam int FI_ID_NOT_FOUND_ERROR = 1;
    localparam int FI_ABORTED_ERROR = 0;

    localparam int HOB_BIT = 7;
    localparam int DL_STREAM_LSB = 8;

    localparam int LBA_W = 48;
    localparam int CNT_W = 17;
    localparam int LIM_W = 40;
    localparam logic [16:0] FULL_COUNT = 17'h10000;

    // Microsecond time base
    localparam int CLK_PERIOD_NS = 40;
    localparam int US_NS = 1000;
    localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;

    typedef enum {ST_IDLE, ST_RUN} src_state_e;

endpackage : src_pkg

// file: tb/src_media_model.sv
`timescale 1ns/1ps
module src_media_model
    import src_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Command from the block
    input wire logic start_i,
    input wire logic stop_i,
    input wire logic [CNT_W-1:0] count_i,
    // Test knobs
    input wire logic [7:0] gap_i,
    input wire logic [CNT_W-1:0] bad_lo_i,
    input wire logic [CNT_W-1:0] bad_hi_i,
    input wire logic [3:0] kind_i,
    // Sector results
    output logic done_o,
    output logic bad_o,
    output logic [3:0] fault_o,
    output logic [CNT_W-1:0] sent_o
);
    logic [CNT_W-1:0] left_ff;
    logic [7:0] wait_ff;

    // Fault type is junk unless qualified by bad
    assign fault_o = bad_o ? kind_i : ~kind_i;

    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        bad_o <= 1'b0;
        if (rst_i || stop_i) begin
            left_ff <= '0;
        end else if (start_i) begin
            left_ff <= count_i;
            wait_ff <= gap_i;
            sent_o <= '0;
        end else if (left_ff != '0) begin
            if (wait_ff != 8'h00) begin
                wait_ff <= wait_ff - 8'h01;
            end else begin
                done_o <= 1'b1;
                bad_o <= (sent_o + 17'h1 >= bad_lo_i) &&
                         (sent_o + 17'h1 <= bad_hi_i);
                sent_o <= sent_o + 17'h1;
                left_ff <= left_ff - 17'h1;
                wait_ff <= gap_i;
            end
        end
        if (rst_i) begin
            sent_o <= '0;
        end
    end
endmodule : src_media_model

// file: tb/src_ctrl_tb.sv
`timescale 1ns/1ps
module src_ctrl_tb;
    import src_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, dat_o, q;
    logic ack, start, stop, done, bad, intrq;
    logic urgent_flag, cont, nseq, resm;
    logic [3:0] flt, kind = 4'h0;
    logic [LBA_W-1:0] lba;
    logic [CNT_W-1:0] cnt, sent, bad_lo = '0, bad_hi = '0;
    logic [2:0] strm;
    logic [7:0] gap = 8'h02;
    int fail_count = 0, n_checks = 0, starts = 0, stops = 0, span;

    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        starts += int'(start === 1'b1);
        stops += int'(stop === 1'b1);
    end

    src_ctrl #(.MIN_LIMIT_US(40'h00_0000_0002)) dut_u (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .media_start_o(start), .media_stop_o(stop),
        .media_lba_o(lba), .media_count_o(cnt), .media_urgent_o(urgent_flag),
        .media_continuous_o(cont), .media_not_seq_o(nseq),
        .media_resume_o(resm), .media_stream_o(strm), .sector_done_i(done),
        .sector_bad_i(bad), .sector_fault_i(flt), .intrq_o(intrq));

    src_media_model media_u (.clk_i(clk_i), .rst_i(rst_i), .start_i(start),
        .stop_i(stop), .count_i(cnt), .gap_i(gap), .bad_lo_i(bad_lo),
        .bad_hi_i(bad_hi), .kind_i(kind), .done_o(done), .bad_o(bad),
        .fault_o(flt), .sent_o(sent));

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    task automatic check(input string nm, input logic [47:0] e,
            input logic [47:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    // Classic cycle: hold everything until ack is sampled
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : xfer

    task automatic rd(input string nm, input logic [7:0] a,
            input logic [7:0] e);
        xfer(1'b0, a, 32'h0);
        check(nm, {40'h0, e}, {16'h0, q});
    endtask : rd

    // Previous byte first, then current; then wait for completion
    task automatic issue(input logic [7:0] opc, input logic [15:0] fe,
            input logic [15:0] ct, input logic [47:0] a);
        xfer(1'b1, OFF_FEATURE, {24'h0, fe[15:8]});
        xfer(1'b1, OFF_FEATURE, {24'h0, fe[7:0]});
        xfer(1'b1, OFF_COUNT, {24'h0, ct[15:8]});
        xfer(1'b1, OFF_COUNT, {24'h0, ct[7:0]});
        xfer(1'b1, OFF_ADDR_LOW, {24'h0, a[31:24]});
        xfer(1'b1, OFF_ADDR_LOW, {24'h0, a[7:0]});
        xfer(1'b1, OFF_ADDR_MID, {24'h0, a[39:32]});
        xfer(1'b1, OFF_ADDR_MID, {24'h0, a[15:8]});
        xfer(1'b1, OFF_ADDR_HIGH, {24'h0, a[47:40]});
        xfer(1'b1, OFF_ADDR_HIGH, {24'h0, a[23:16]});
        xfer(1'b1, OFF_OPCODE, {24'h0, opc});
        span = 0;
        while (intrq !== 1'b1 && span < 3000) begin
            @(posedge clk_i);
            span++;
        end
        @(posedge clk_i);
    endtask : issue

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd("status", OFF_OPCODE, 8'h40);
        rd("fault", OFF_FAULT, 8'h00);
        rd("ident", OFF_IDENT, 8'h01);
        xfer(1'b1, 8'h40, 32'h5A);
        rd("unmapped", 8'h40, 8'h00);
        xfer(1'b1, OFF_DRIVE, 32'hE0);
        rd("drive", OFF_DRIVE, 8'hE0);
        xfer(1'b1, OFF_OPCODE, 32'h24);
        repeat (3) @(posedge clk_i);
        check("bad_opc_starts", 0, starts);
    endtask : t_reset

    // Zero count, plain timeout, limit raised to the minimum
    task automatic t_plain_timeout();
        issue(OPC_STREAM_PIO, 16'h01A5, 16'h0000, 48'h0);
        check("count", FULL_COUNT, cnt);
        check("flags", 5'b10101, {urgent_flag, cont, nseq, resm, 1'b1});
        check("stream", 5, strm);
        check("not_seq", 1, nseq);
        check("span", 1, span >= 45 && span <= 58);
        rd("status", OFF_OPCODE, 8'h41);
        rd("fault", OFF_FAULT, 8'h01);
        check("stops", 1, stops);
    endtask : t_plain_timeout

    task automatic t_plain_bad();
        gap = 8'h01;
        bad_lo = 17'h2;
        bad_hi = 17'h2;
        kind = 4'h4;
        issue(OPC_STREAM_DMA, 16'h0000, 16'h0003, 48'hA1B2C3D4E5F6);
        check("lba", 48'hA1B2C3D4E5F6, lba);
        check("sent", 2, sent);
        rd("status", OFF_OPCODE, 8'h41);
        rd("fault", OFF_FAULT, 8'h40);
        rd("addr_low", OFF_ADDR_LOW, 8'hF7);
        xfer(1'b1, OFF_HOB, 32'h80);
        rd("addr_low_hob", OFF_ADDR_LOW, 8'hC3);
        rd("addr_high_hob", OFF_ADDR_HIGH, 8'hA1);
        xfer(1'b1, OFF_HOB, 32'h00);
    endtask : t_plain_bad

    // Errors under continuous read do not stop the transfer
    task automatic t_cont_bad();
        bad_lo = 17'h2;
        bad_hi = 17'h3;
        kind = 4'h8;
        issue(OPC_STREAM_DMA, 16'h0043, 16'h0005, 48'h100);
        check("sent", 5, sent);
        check("stops", 2, stops);
        rd("status", OFF_OPCODE, 8'h60);
        rd("fault", OFF_FAULT, 8'h00);
        rd("log", OFF_ERRLOG, 8'h80);
        rd("addr_low", OFF_ADDR_LOW, 8'h01);
        rd("addr_mid", OFF_ADDR_MID, 8'h01);
        rd("count", OFF_COUNT, 8'h02);
        bad_lo = '0;
        bad_hi = '0;
        issue(OPC_STREAM_PIO, 16'h0053, 16'h0001, 48'h5000);
        check("resume_lba", 48'h101, lba);
        check("resume", 1, resm);
        rd("status", OFF_OPCODE, 8'h40);
    endtask : t_cont_bad

    // Stream default limit, expiry under continuous read
    task automatic t_cont_timeout();
        gap = 8'h03;
        xfer(1'b1, OFF_DEFLIM, 32'h301);
        issue(OPC_STREAM_DMA, 16'h0043, 16'h0064, 48'h0);
        check("span", 1, span >= 45 && span <= 58);
        check("stops", 3, stops);
        rd("status", OFF_OPCODE, 8'h60);
        rd("fault", OFF_FAULT, 8'h01);
        rd("log", OFF_ERRLOG, 8'h01);
    endtask : t_cont_timeout

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_plain_timeout();
        t_plain_bad();
        t_cont_bad();
        t_cont_timeout();
        stop_test();
    end

    // Whole run needs well under 5000 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        stop_test();
    end
endmodule : src_ctrl_tb
